// ==== fms_host_model.sv ====
`timescale 1ns/1ps
module fms_host_model (
  input  wire logic          clk_in,
  input  wire logic          resetn_in,
  input  wire logic          enable_in,
  input  wire logic          bad_toggle_in,
  input  wire logic          bad_length_in,
  output fms_pkg::fms_frame_t frame_out
);
  // ----------------------------------------
  // frame source, one frame per 100 cycles
  // ----------------------------------------
  logic [6:0] gap_r;
  logic       tog_r;
  logic [7:0] cnt_r;

  // host leaves external switch protection to its own firmware; no feedback modelled
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_r <= 7'h00;
      tog_r <= 1'b0;
      cnt_r <= 8'h00;
      frame_out <= '0;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      gap_r <= enable_in ? gap_r + 7'h01 : 7'h00;
      // fields are garbage between frames, never the last value
      frame_out.frame_end <= 1'b0;
      frame_out.toggle_bit <= cnt_r[0];
      frame_out.edge_count <= ~cnt_r;
      if (enable_in && gap_r == 7'h63) begin
        gap_r <= 7'h00;
        frame_out.frame_end <= 1'b1;
        frame_out.toggle_bit <= bad_toggle_in ? tog_r : ~tog_r;
        tog_r <= bad_toggle_in ? tog_r : ~tog_r;
        frame_out.edge_count <= {1'b0, cnt_r[2:0] | 3'h1, bad_length_in ? 4'h8 : 4'h0};
      end
    end
  end
endmodule

// ==== fms_pkg.sv ====
package fms_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned IN_DGL_US       = 200;
  localparam int unsigned RST_DGL_US      = 10;
  localparam int unsigned CLK_DGL_NS      = 2000;
  localparam int unsigned WD_SHORT_MS     = 32;
  localparam int unsigned WD_LONG_MS      = 128;
  localparam int unsigned CLK_LOW_HZ      = 100;
  localparam int unsigned IN_DGL_CYC      = IN_DGL_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RST_DGL_CYC     = RST_DGL_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CLK_DGL_CYC     = CLK_DGL_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_SHORT_CYC    = WD_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_LONG_CYC     = WD_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned CLK_LOW_CYC     = CLK_HZ / CLK_LOW_HZ;
  localparam int unsigned FRAME_MOD       = 16;
  localparam int unsigned NUM_CH          = 4;
  localparam int unsigned CNT_W           = 32;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FMS_SLEEP,
    FMS_NORMAL,
    FMS_FAIL
  } fms_mode_t;

  typedef struct packed {
    logic       frame_end;
    logic       toggle_bit;
    logic [7:0] edge_count;
  } fms_frame_t;

  typedef struct packed {
    logic link_failure_flag;
    logic fail_input_level;
    logic clock_fail;
  } fms_status_t;
endpackage

// ==== fms_supervisor.sv ====
`timescale 1ns/1ps
module fms_supervisor #(
  parameter int unsigned IN_DGL_CYC   = fms_pkg::IN_DGL_CYC,
  parameter int unsigned WD_SHORT_CYC = fms_pkg::WD_SHORT_CYC,
  parameter int unsigned WD_LONG_CYC  = fms_pkg::WD_LONG_CYC,
  parameter int unsigned CLK_LOW_CYC  = fms_pkg::CLK_LOW_CYC,
  parameter int unsigned RST_DGL_CYC  = fms_pkg::RST_DGL_CYC
) (
  input  wire logic                       clk_in,
  input  wire logic                       resetn_in,
  input  wire logic                       fail_request_in,
  input  wire logic [fms_pkg::NUM_CH-1:0] direct_channel_input_in,
  input  wire logic                       reset_input_n_in,
  input  wire logic                       pwm_clock_in,
  input  wire logic                       wake_in,
  input  wire fms_pkg::fms_frame_t        frame_in,
  input  wire logic                       watchdog_period_select_in,
  input  wire logic [fms_pkg::NUM_CH-1:0] channel_onoff_control_in,
  input  wire logic [fms_pkg::NUM_CH-1:0] pwm_channel_in,
  input  wire logic                       channel6_setting_in,
  input  wire logic                       quick_status_read_in,
  output logic      [fms_pkg::NUM_CH-1:0] channel_out,
  output logic                            external_switch_control_out,
  output fms_pkg::fms_status_t            status_out,
  output fms_pkg::fms_mode_t              mode_out,
  output logic                            reset_filtered_n_out
);
  localparam int unsigned W = fms_pkg::CNT_W;
  localparam int unsigned NIN = fms_pkg::NUM_CH + 1;
  default clocking cb_main @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------
  // deglitchers: fail input and direct inputs
  // ----------------------------------------
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] flt_r;
  logic [NIN-1:0] flt_nxt;
  logic [W-1:0]   dcnt_r   [NIN];
  logic [W-1:0]   dcnt_nxt [NIN];
  assign raw_in = {direct_channel_input_in, fail_request_in};
  generate
    for (genvar gi = 0; gi < NIN; gi++) begin : g_dgl
      always_comb begin
        dcnt_nxt[gi] = '0;
        flt_nxt[gi]  = flt_r[gi];
        if (raw_in[gi] != flt_r[gi]) begin
          if (dcnt_r[gi] >= W'(IN_DGL_CYC - 1)) begin
            flt_nxt[gi] = raw_in[gi];
          end else begin
            dcnt_nxt[gi] = dcnt_r[gi] + W'(1);
          end
        end
      end
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          dcnt_r[gi] <= '0;
          flt_r[gi]  <= 1'b0;
        end else begin
          dcnt_r[gi] <= dcnt_nxt[gi];
          flt_r[gi]  <= flt_nxt[gi];
        end
      end
    end
  endgenerate
  wire logic                       filtered_fail_request = flt_r[0];
  wire logic [fms_pkg::NUM_CH-1:0] filtered_direct_input = flt_r[NIN-1:1];
  // ----------------------------------------
  // reset input: falling edge filtered only
  // ----------------------------------------
  logic         rst_f_r;
  logic         rst_f_nxt;
  logic [W-1:0] rcnt_r;
  logic [W-1:0] rcnt_nxt;
  always_comb begin
    rst_f_nxt = rst_f_r;
    rcnt_nxt  = '0;
    if (reset_input_n_in) begin
      rst_f_nxt = 1'b1;  // rise passes at once
    end else if (rst_f_r) begin
      if (rcnt_r >= W'(RST_DGL_CYC - 1)) begin
        rst_f_nxt = 1'b0;
      end else begin
        rcnt_nxt = rcnt_r + W'(1);
      end
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_f_r <= 1'b0;
      rcnt_r  <= '0;
    end else begin
      rst_f_r <= rst_f_nxt;
      rcnt_r  <= rcnt_nxt;
    end
  end
  // ----------------------------------------
  // pwm clock deglitch and low-frequency monitor
  // ----------------------------------------
  logic         cflt_r;
  logic         cflt_nxt;
  logic [W-1:0] ccnt_r;
  logic [W-1:0] ccnt_nxt;
  logic [W-1:0] per_r;
  logic [W-1:0] per_nxt;
  logic         slow_r;
  logic         slow_nxt;
  logic         cfail_r;
  logic         cfail_nxt;
  logic         rst_f_d_r;
  always_comb begin
    cflt_nxt = cflt_r;
    ccnt_nxt = '0;
    if (pwm_clock_in != cflt_r) begin
      if (ccnt_r >= W'(fms_pkg::CLK_DGL_CYC - 1)) begin
        cflt_nxt = pwm_clock_in;
      end else begin
        ccnt_nxt = ccnt_r + W'(1);
      end
    end
    // too-fast input never settles, so no filtered edge arrives and it looks slow
    per_nxt  = per_r;
    slow_nxt = slow_r;
    if (rst_f_r && !rst_f_d_r) begin  // restart at reset rise
      per_nxt  = '0;
      slow_nxt = 1'b0;
    end else if (!rst_f_r) begin
      per_nxt = '0;
    end else if (cflt_nxt && !cflt_r) begin
      per_nxt  = '0;
      slow_nxt = 1'b0;
    end else if (per_r >= W'(CLK_LOW_CYC - 1)) begin
      slow_nxt = 1'b1;
    end else begin
      per_nxt = per_r + W'(1);
    end
    cfail_nxt = cfail_r;
    if (slow_nxt) begin
      cfail_nxt = 1'b1;  // set wins over read
    end else if (quick_status_read_in) begin
      cfail_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cflt_r    <= 1'b0;
      ccnt_r    <= '0;
      per_r     <= '0;
      slow_r    <= 1'b0;
      cfail_r   <= 1'b0;
      rst_f_d_r <= 1'b0;
    end else begin
      cflt_r    <= cflt_nxt;
      ccnt_r    <= ccnt_nxt;
      per_r     <= per_nxt;
      slow_r    <= slow_nxt;
      cfail_r   <= cfail_nxt;
      rst_f_d_r <= rst_f_r;
    end
  end
  // ----------------------------------------
  // link watchdog and mode
  // ----------------------------------------
  logic               tog_r;
  logic               tog_nxt;
  logic [W-1:0]       wd_r;
  logic [W-1:0]       wd_nxt;
  logic               flag_r;
  logic               flag_nxt;
  logic               link_fault;
  fms_pkg::fms_mode_t mode_r;
  fms_pkg::fms_mode_t mode_nxt;
  logic [W-1:0]       wd_lim;
  assign wd_lim = watchdog_period_select_in ? W'(WD_LONG_CYC - 1) : W'(WD_SHORT_CYC - 1);
  always_comb begin
    link_fault = 1'b0;
    tog_nxt    = tog_r;
    wd_nxt     = wd_r;
    if (mode_r == fms_pkg::FMS_SLEEP) begin
      wd_nxt = '0;
    end else if (frame_in.frame_end) begin
      wd_nxt  = '0;
      tog_nxt = frame_in.toggle_bit;
      if (frame_in.toggle_bit == tog_r) begin
        link_fault = 1'b1;
      end
      if ((frame_in.edge_count & 8'(fms_pkg::FRAME_MOD - 1)) != 8'h00) begin
        link_fault = 1'b1;
      end
    end else if (wd_r >= wd_lim) begin
      link_fault = 1'b1;
      wd_nxt     = '0;
    end else begin
      wd_nxt = wd_r + W'(1);
    end
    mode_nxt = mode_r;
    unique case (mode_r)
      fms_pkg::FMS_SLEEP: begin
        if (wake_in) begin
          mode_nxt = filtered_fail_request ? fms_pkg::FMS_FAIL : fms_pkg::FMS_NORMAL;
        end
      end
      fms_pkg::FMS_NORMAL: begin
        if (!wake_in) begin
          mode_nxt = fms_pkg::FMS_SLEEP;
        end else if (filtered_fail_request || link_fault) begin
          mode_nxt = fms_pkg::FMS_FAIL;
        end
      end
      fms_pkg::FMS_FAIL: begin
        if (!wake_in) begin
          mode_nxt = fms_pkg::FMS_SLEEP;
        end else if (!filtered_fail_request && frame_in.frame_end && !link_fault) begin
          mode_nxt = fms_pkg::FMS_NORMAL;  // valid frame recovers the link
        end
      end
      default: mode_nxt = fms_pkg::FMS_SLEEP;
    endcase
    flag_nxt = flag_r;
    if (link_fault) begin
      flag_nxt = 1'b1;  // set wins
    end else if (mode_r == fms_pkg::FMS_FAIL && mode_nxt == fms_pkg::FMS_NORMAL) begin
      flag_nxt = 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tog_r  <= 1'b0;
      wd_r   <= '0;
      flag_r <= 1'b0;
      mode_r <= fms_pkg::FMS_SLEEP;
    end else begin
      tog_r  <= tog_nxt;
      wd_r   <= wd_nxt;
      flag_r <= flag_nxt;
      mode_r <= mode_nxt;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic [fms_pkg::NUM_CH-1:0] ch_nxt;
  logic                       ext_nxt;
  always_comb begin
    ch_nxt  = '0;
    ext_nxt = 1'b0;
    unique case (mode_r)
      fms_pkg::FMS_FAIL:   ch_nxt = filtered_direct_input;
      fms_pkg::FMS_NORMAL: begin
        ch_nxt  = slow_r ? channel_onoff_control_in : pwm_channel_in;
        ext_nxt = channel6_setting_in;
      end
      default: ch_nxt = '0;
    endcase
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      channel_out                 <= '0;
      external_switch_control_out <= 1'b0;
      status_out                  <= '0;
      mode_out                    <= fms_pkg::FMS_SLEEP;
      reset_filtered_n_out        <= 1'b0;
    end else begin
      channel_out                 <= ch_nxt;
      external_switch_control_out <= ext_nxt;
      status_out.link_failure_flag <= flag_nxt;
      status_out.fail_input_level  <= fail_request_in;
      status_out.clock_fail        <= cfail_nxt;
      mode_out                    <= mode_nxt;
      reset_filtered_n_out        <= rst_f_nxt;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_fail_entry;
    (mode_r == fms_pkg::FMS_NORMAL && wake_in && filtered_fail_request) |=> mode_r == fms_pkg::FMS_FAIL;
  endproperty
  a_fail_entry: assert property (p_fail_entry) else $error("fail request ignored");
  property p_fault_entry;
    (mode_r == fms_pkg::FMS_NORMAL && wake_in && link_fault) |=> mode_r == fms_pkg::FMS_FAIL && flag_r;
  endproperty
  a_fault_entry: assert property (p_fault_entry) else $error("link fault ignored");
  // judged on the mode and flag it causes, not on the internal fault strobe
  property p_toggle;
    (mode_r == fms_pkg::FMS_NORMAL && wake_in && frame_in.frame_end && frame_in.toggle_bit == tog_r)
      |=> mode_r == fms_pkg::FMS_FAIL && flag_r;
  endproperty
  a_toggle: assert property (p_toggle) else $error("missing toggle not flagged");
  property p_flag_hold;
    (flag_r && mode_r == fms_pkg::FMS_FAIL && mode_nxt == fms_pkg::FMS_FAIL) |=> flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost in fail mode");
  property p_fail_drive;
    mode_r == fms_pkg::FMS_FAIL |=> channel_out == $past(filtered_direct_input) && !external_switch_control_out;
  endproperty
  a_fail_drive: assert property (p_fail_drive) else $error("fail mode drive wrong");
  property p_dgl_stable;
    $rose(flt_r[0]) |-> $past(fail_request_in, 2) && $past(dcnt_r[0]) == W'(IN_DGL_CYC - 1);
  endproperty
  a_dgl_stable: assert property (p_dgl_stable) else $error("fail input deglitch short");
  property p_rst_rise;
    reset_input_n_in |=> rst_f_r;
  endproperty
  a_rst_rise: assert property (p_rst_rise) else $error("reset rise delayed");
  property p_cfail_clear;
    $fell(cfail_r) |-> $past(quick_status_read_in) && !$past(slow_nxt);
  endproperty
  a_cfail_clear: assert property (p_cfail_clear) else $error("clock fail cleared early");
  property p_ext;
    mode_r == fms_pkg::FMS_NORMAL |=> external_switch_control_out == $past(channel6_setting_in);
  endproperty
  a_ext: assert property (p_ext) else $error("external switch wrong");
  c_fail:  cover property (@(posedge clk_in) disable iff (!resetn_in) mode_r == fms_pkg::FMS_FAIL);
  c_recov: cover property (@(posedge clk_in) disable iff (!resetn_in) $fell(flag_r));
  c_slow:  cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(slow_r));
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic                       clk_in = 1'b0;
  logic                       resetn_in = 1'b0;
  logic                       fail_request_in = 1'b0;
  logic [3:0]                 direct_channel_input_in = 4'h0;
  logic                       reset_input_n_in = 1'b1;
  logic                       pwm_clock_in = 1'b0;
  logic                       wake_in = 1'b0;
  logic                       period_sel = 1'b0;
  logic [3:0]                 channel_onoff_control_in = 4'h0;
  logic [3:0]                 pwm_channel_in = 4'h0;
  logic                       channel6_setting_in = 1'b0;
  logic                       quick_status_read_in = 1'b0;
  logic                       host_en = 1'b0;
  logic                       bad_tog = 1'b0;
  logic                       bad_len = 1'b0;
  fms_pkg::fms_frame_t        frame;
  logic [3:0]                 channel_out;
  logic                       external_switch_control_out;
  fms_pkg::fms_status_t       status_out;
  fms_pkg::fms_mode_t         mode_out;
  logic                       reset_filtered_n_out;
  int                         errors = 0;
  int                         check_count = 0;
  int                         seed = 33696;
  int                         pwm_half = 300;
  logic [3:0]                 d;

  fms_host_model host (.clk_in(clk_in), .resetn_in(resetn_in), .enable_in(host_en), .bad_toggle_in(bad_tog),
                       .bad_length_in(bad_len), .frame_out(frame));
  fms_supervisor #(.IN_DGL_CYC(20), .WD_SHORT_CYC(200), .WD_LONG_CYC(400), .CLK_LOW_CYC(1000), .RST_DGL_CYC(10))
    uut (.clk_in(clk_in), .resetn_in(resetn_in), .fail_request_in(fail_request_in),
         .direct_channel_input_in(direct_channel_input_in), .reset_input_n_in(reset_input_n_in),
         .pwm_clock_in(pwm_clock_in), .wake_in(wake_in), .frame_in(frame), .watchdog_period_select_in(period_sel),
         .channel_onoff_control_in(channel_onoff_control_in), .pwm_channel_in(pwm_channel_in),
         .channel6_setting_in(channel6_setting_in), .quick_status_read_in(quick_status_read_in),
         .channel_out(channel_out), .external_switch_control_out(external_switch_control_out),
         .status_out(status_out), .mode_out(mode_out), .reset_filtered_n_out(reset_filtered_n_out));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    forever begin
      repeat (pwm_half) @(posedge clk_in);
      pwm_clock_in <= ~pwm_clock_in;
    end
  end
  initial begin
    #(8 * 20000);
    $display("[FAIL] watchdog expired");
    errors++;
    tally_and_finish();
  end

  function automatic logic [3:0] exp_ch(input fms_pkg::fms_mode_t m, input logic slow);
    if (m == fms_pkg::FMS_FAIL) return direct_channel_input_in;
    return slow ? channel_onoff_control_in : pwm_channel_in;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // leaves the caller 2 ns after the edge that carried the frame
  task automatic wait_frame();
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_in);
      #2;
      if (frame.frame_end === 1'b1) return;
    end
    chk("frame_seen", 4'h1, 4'h0);
  endtask

  task automatic recover();
    wait_frame();
    step(3);
    #2;
    chk("mode_back", fms_pkg::FMS_NORMAL, mode_out);
    chk("flag_clear", 4'h0, status_out.link_failure_flag);
    step(1);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    step(4);
    resetn_in <= 1'b1;
    #2;
    chk("mode_rst", fms_pkg::FMS_SLEEP, mode_out);
    chk("ext_rst", 4'h0, external_switch_control_out);
    step(1);
    wake_in <= 1'b1;
    host_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      step(1);
      pwm_channel_in <= 4'($random(seed));
      channel_onoff_control_in <= 4'($random(seed));
      channel6_setting_in <= (i == 0) || seed[0];
      step(5);
      #2;
      chk("ch_norm", exp_ch(fms_pkg::FMS_NORMAL, 1'b0), channel_out);
      chk("ext_norm", channel6_setting_in, external_switch_control_out);
    end
    bad_tog <= 1'b1;
    wait_frame();
    step(1);
    bad_tog <= 1'b0;
    d = 4'($random(seed));
    direct_channel_input_in <= d;
    #2;
    chk("mode_tog", fms_pkg::FMS_FAIL, mode_out);
    chk("flag_set", 4'h1, status_out.link_failure_flag);
    step(25);
    #2;
    chk("ch_direct", d, channel_out);
    chk("ext_fail", 4'h0, external_switch_control_out);
    step(1);
    direct_channel_input_in <= ~d;
    step(10);
    direct_channel_input_in <= d;
    step(15);
    #2;
    chk("ch_glitch", d, channel_out);
    chk("flag_hold", 4'h1, status_out.link_failure_flag);
    recover();
    bad_len <= 1'b1;
    wait_frame();
    step(1);
    bad_len <= 1'b0;
    #2;
    chk("mode_len", fms_pkg::FMS_FAIL, mode_out);
    recover();
    for (int s = 0; s < 2; s++) begin
      step(1);
      period_sel <= s[0];
      host_en <= 1'b0;
      step(s ? 290 : 90);
      #2;
      chk("wd_early", fms_pkg::FMS_NORMAL, mode_out);
      step(130);
      #2;
      chk("wd_late", fms_pkg::FMS_FAIL, mode_out);
      step(1);
      host_en <= 1'b1;
      recover();
    end
    fail_request_in <= 1'b1;
    step(10);
    fail_request_in <= 1'b0;
    step(30);
    #2;
    chk("fail_glitch", fms_pkg::FMS_NORMAL, mode_out);
    step(1);
    fail_request_in <= 1'b1;
    step(3);
    #2;
    chk("fail_level", 4'h1, status_out.fail_input_level);
    step(25);
    #2;
    chk("mode_pin", fms_pkg::FMS_FAIL, mode_out);
    step(1);
    fail_request_in <= 1'b0;
    step(25);
    recover();
    pwm_half = 10;
    step(1100);
    channel_onoff_control_in <= 4'($random(seed));
    step(5);
    #2;
    chk("clk_fast", 4'h1, status_out.clock_fail);
    chk("ch_slow", exp_ch(fms_pkg::FMS_NORMAL, 1'b1), channel_out);
    step(1);
    pwm_half = 300;
    step(900);
    #2;
    chk("clk_latch", 4'h1, status_out.clock_fail);
    step(1);
    quick_status_read_in <= 1'b1;
    pwm_channel_in <= 4'($random(seed));
    step(1);
    quick_status_read_in <= 1'b0;
    step(4);
    #2;
    chk("clk_clear", 4'h0, status_out.clock_fail);
    chk("ch_valid", exp_ch(fms_pkg::FMS_NORMAL, 1'b0), channel_out);
    for (int w = 5; w <= 20; w += 15) begin
      step(1);
      reset_input_n_in <= 1'b0;
      step(w);
      #2;
      chk("rst_filt", w > 10 ? 4'h0 : 4'h1, reset_filtered_n_out);
      step(1);
      reset_input_n_in <= 1'b1;
      step(2);
      #2;
      chk("rst_rise", 4'h1, reset_filtered_n_out);
    end
    step(1);
    channel6_setting_in <= 1'b1;
    wake_in <= 1'b0;
    step(3);
    #2;
    chk("mode_sleep", fms_pkg::FMS_SLEEP, mode_out);
    chk("ext_sleep", 4'h0, external_switch_control_out);
    tally_and_finish();
  end
endmodule
